// ### rtl/cfg_gate_defines.svh
`ifndef CFG_GATE_DEFINES_SVH
`define CFG_GATE_DEFINES_SVH

// clock and timing
`define CLK_HZ 40000000
`define TICK_S 1
`define CMD_DELAY_MS 500

// apb byte offsets
`define OFF_CTRL 8'h00
`define OFF_TX_STORED 8'h04
`define OFF_TX_ACTIVE 8'h08
`define OFF_TIMER 8'h0c
`define OFF_GPIO 8'h10
`define OFF_PROFILE 8'h14
`define OFF_STATUS 8'h18
`define OFF_LINK 8'h1c

// ctrl fields
`define CTRL_ROLE_LSB 0
`define CTRL_HCI_BIT 4
`define CTRL_USB_BIT 5
`define CTRL_REBOOT_BIT 8
`define CTRL_EXIT_BIT 9

// reset values and codes
`define RST_TX_CODE 16'h0010
`define RST_TIMER 8'h3c
`define TX_MAX 16'h0010
`define TX_MIN 16'hfff4
`define GPIO_ALL_IN 16'h1000
`define TMR_LAST_SEC 8'hfc
`define TMR_LOCAL 8'hfd
`define TMR_REMOTE 8'hfe
`define TMR_BOTH 8'hff
`define PROF_MAX 3'h6
`define PROF_HID 3'h6
`define PROF_MDM 3'h3
`define DOLLAR 8'h24

`endif

// ### rtl/cfg_gate_pkg.sv
package cfg_gate_pkg;
    typedef enum logic [1:0] {
        ROLE_SLAVE = 2'h0,
        ROLE_MASTER = 2'h1,
        ROLE_TRIG_MASTER = 2'h2,
        ROLE_AUTO_SLAVE = 2'h3
    } role_t;
    typedef enum logic [1:0] {
        ESC_IDLE = 2'h0,
        ESC_ONE = 2'h1,
        ESC_TWO = 2'h3,
        ESC_CMD = 2'h2
    } esc_state_t;
    typedef enum logic [1:0] {
        SVC_NONE = 2'h0,
        SVC_SERIAL = 2'h1,
        SVC_DIALUP = 2'h2
    } svc_t;
endpackage

// ### rtl/config_gate_and_tx_power_ctl.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gate_defines.svh"

module config_gate_and_tx_power_ctl
    import cfg_gate_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_S * `CLK_HZ,
    parameter int unsigned CMD_DELAY_CYCLES = `CMD_DELAY_MS * (`CLK_HZ / 1000)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_rx_valid,
    input wire logic [7:0] host_rx_data,
    output logic host_rx_ready,
    output logic radio_tx_valid,
    output logic [7:0] radio_tx_data,
    input wire logic radio_tx_ready,
    input wire logic remote_rx_valid,
    input wire logic [7:0] remote_rx_data,
    output logic remote_rx_ready,
    output logic host_tx_valid,
    output logic [7:0] host_tx_data,
    input wire logic cts_n,
    output logic rts_n,
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic cmd_remote,
    input wire logic conn_req_serial,
    input wire logic conn_req_dialup,
    input wire logic conn_drop,
    output logic link_up,
    output logic [1:0] link_service,
    output logic [11:0] gpio_oe,
    output logic [15:0] tx_level,
    output logic stack_bypass,
    output logic usb_device_mode,
    output logic modem_ctl_en,
    output logic hid_en,
    output logic cmd_mode
);
    localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);
    localparam logic [24:0] CMD_LAST = 25'(CMD_DELAY_CYCLES - 1);

    logic [1:0] role_q;
    logic hci_q, usb_q, reboot_q, exit_q;
    logic [15:0] tx_code_q, tx_level_q;
    logic [7:0] timer_q, secs_q, idle_q;
    logic [11:0] gpio_oe_q;
    logic [2:0] profile_q;
    logic [25:0] tick_cnt_q;
    logic tick;
    logic [24:0] boot_cnt_q;
    logic cmd_ready_q;
    logic cts_s1_q, cts_s2_q;
    esc_state_t esc_q;
    logic link_q, idle_drop;
    svc_t svc_q;
    logic radio_v_q, host_v_q, cmd_v_q, cmd_rem_q;
    logic [7:0] radio_d_q, host_d_q, cmd_d_q;
    logic [31:0] prdata_q;
    logic [7:0] eff_timer;
    logic in_win, local_ok, remote_ok, host_take, remote_take, to_cmd;
    logic wr, rd_setup, mapped;
    logic signed [15:0] code_s;
    logic [15:0] level_pick;

    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);

    // master modes and auto slave see a zero remote timer
    always_comb begin
        eff_timer = timer_q;
        if (role_q != ROLE_SLAVE) begin
            eff_timer = 8'h00;
        end
    end

    // window decode
    assign in_win = (eff_timer != 8'h00) && (eff_timer <= `TMR_LAST_SEC) && (secs_q < eff_timer);
    assign local_ok = cmd_ready_q && ((eff_timer == `TMR_BOTH) || (eff_timer == `TMR_LOCAL) || in_win
        || ((eff_timer == 8'h00) && !link_q));
    assign remote_ok = link_q && !hci_q && ((eff_timer == `TMR_BOTH) || (eff_timer == `TMR_REMOTE)
        || in_win);

    // largest supported level not above the stored signed code, or the lowest level if none is
    always_comb begin
        code_s = signed'(tx_code_q);
        level_pick = tx_code_q & 16'hfffc;
        if (code_s >= signed'(`TX_MAX)) begin
            level_pick = `TX_MAX;
        end else if (code_s < signed'(`TX_MIN)) begin
            level_pick = `TX_MIN;
        end
    end

    // apb write side: control, stored code, timer, profile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            role_q <= ROLE_SLAVE;
            hci_q <= 1'b0;
            usb_q <= 1'b0;
            tx_code_q <= `RST_TX_CODE;
            timer_q <= `RST_TIMER;
            profile_q <= 3'h0;
        end else if (wr && mapped) begin
            unique case (paddr)
                `OFF_CTRL: begin
                    role_q <= pwdata[`CTRL_ROLE_LSB +: 2];
                    hci_q <= pwdata[`CTRL_HCI_BIT];
                    usb_q <= pwdata[`CTRL_USB_BIT];
                end
                `OFF_TX_STORED: tx_code_q <= pwdata[15:0];
                `OFF_TIMER: timer_q <= pwdata[7:0];
                `OFF_PROFILE: begin
                    if (pwdata[2:0] <= `PROF_MAX) begin
                        profile_q <= pwdata[2:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // one-cycle strobes from ctrl writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reboot_q <= 1'b1;
            exit_q <= 1'b0;
        end else begin
            reboot_q <= wr && (paddr == `OFF_CTRL) && pwdata[`CTRL_REBOOT_BIT];
            exit_q <= wr && (paddr == `OFF_CTRL) && pwdata[`CTRL_EXIT_BIT];
        end
    end

    // active level loads only on reset release or reboot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_level_q <= `RST_TX_CODE;
        end else if (reboot_q) begin
            tx_level_q <= level_pick;
        end
    end

    // gpio direction, all inputs on the 1000 code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_oe_q <= 12'h000;
        end else if (wr && (paddr == `OFF_GPIO)) begin
            if (pwdata[15:0] == `GPIO_ALL_IN) begin
                gpio_oe_q <= 12'h000;
            end else begin
                gpio_oe_q <= pwdata[11:0];
            end
        end
    end

    // one-second tick and seconds since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 26'h0;
            secs_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick ? 26'h0 : tick_cnt_q + 26'h1;
            if (tick && secs_q != 8'hff) begin
                secs_q <= secs_q + 8'h01;
            end
        end
    end
    assign tick = (tick_cnt_q == TICK_LAST);

    // command-mode entry delay after boot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_q <= 25'h0;
            cmd_ready_q <= 1'b0;
        end else if (!cmd_ready_q) begin
            boot_cnt_q <= boot_cnt_q + 25'h1;
            cmd_ready_q <= (boot_cnt_q == CMD_LAST);
        end
    end

    // cts pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
        end else begin
            cts_s1_q <= cts_n;
            cts_s2_q <= cts_s1_q;
        end
    end

    // byte acceptance and routing
    assign host_rx_ready = !radio_v_q;
    assign remote_rx_ready = !host_v_q;
    assign host_take = host_rx_valid && host_rx_ready;
    assign remote_take = remote_rx_valid && remote_rx_ready && link_q;
    assign to_cmd = !hci_q && (esc_q == ESC_CMD);

    // escape detector on host bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esc_q <= ESC_IDLE;
        end else if (hci_q || exit_q || !local_ok) begin
            esc_q <= ESC_IDLE;
        end else if (host_take && esc_q != ESC_CMD) begin
            unique case (esc_q)
                ESC_IDLE: esc_q <= (host_rx_data == `DOLLAR) ? ESC_ONE : ESC_IDLE;
                ESC_ONE: esc_q <= (host_rx_data == `DOLLAR) ? ESC_TWO : ESC_IDLE;
                ESC_TWO: esc_q <= (host_rx_data == `DOLLAR) ? ESC_CMD : ESC_IDLE;
                ESC_CMD: esc_q <= ESC_CMD;
            endcase
        end
    end

    // host to radio path, held until the radio takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            radio_v_q <= 1'b0;
            radio_d_q <= 8'h00;
        end else if (host_take && !to_cmd) begin
            radio_v_q <= 1'b1;
            radio_d_q <= host_rx_data;
        end else if (radio_tx_ready) begin
            radio_v_q <= 1'b0;
        end
    end

    // remote to host path, held while the host raises cts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_v_q <= 1'b0;
            host_d_q <= 8'h00;
        end else if (remote_take && !remote_ok) begin
            host_v_q <= 1'b1;
            host_d_q <= remote_rx_data;
        end else if (!cts_s2_q) begin
            host_v_q <= 1'b0;
        end
    end

    // interpreter feed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_v_q <= 1'b0;
            cmd_d_q <= 8'h00;
            cmd_rem_q <= 1'b0;
        end else begin
            cmd_v_q <= (host_take && to_cmd) || (remote_take && remote_ok);
            if (host_take && to_cmd) begin
                cmd_d_q <= host_rx_data;
                cmd_rem_q <= 1'b0;
            end else if (remote_take && remote_ok) begin
                cmd_d_q <= remote_rx_data;
                cmd_rem_q <= 1'b1;
            end
        end
    end

    // idle drop in trigger master mode
    assign idle_drop = link_q && (role_q == ROLE_TRIG_MASTER) && (timer_q != 8'h00)
        && (timer_q <= `TMR_LAST_SEC) && (idle_q >= timer_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 8'h00;
        end else if (!link_q || host_take || remote_take) begin
            idle_q <= 8'h00;
        end else if (tick && idle_q != 8'hff) begin
            idle_q <= idle_q + 8'h01;
        end
    end

    // single service connection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q <= 1'b0;
            svc_q <= SVC_NONE;
        end else if (conn_drop || idle_drop) begin
            link_q <= 1'b0;
            svc_q <= SVC_NONE;
        end else if (!link_q && (conn_req_serial || conn_req_dialup)) begin
            link_q <= 1'b1;
            svc_q <= conn_req_serial ? SVC_SERIAL : SVC_DIALUP;
        end
    end

    // apb read data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (rd_setup) begin
            prdata_q <= 32'h0;
            unique case (paddr)
                `OFF_CTRL: prdata_q <= {26'h0, usb_q, hci_q, 2'h0, role_q};
                `OFF_TX_STORED: prdata_q <= {16'h0, tx_code_q};
                `OFF_TX_ACTIVE: prdata_q <= {16'h0, tx_level_q};
                `OFF_TIMER: prdata_q <= {24'h0, timer_q};
                `OFF_GPIO: prdata_q <= {20'h0, gpio_oe_q};
                `OFF_PROFILE: prdata_q <= {29'h0, profile_q};
                `OFF_STATUS: prdata_q <= {16'h0, secs_q, 2'h0, idle_drop, to_cmd, cmd_ready_q,
                    remote_ok, local_ok, in_win};
                `OFF_LINK: prdata_q <= {29'h0, svc_q, link_q};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign radio_tx_valid = radio_v_q;
    assign radio_tx_data = radio_d_q;
    assign host_tx_valid = host_v_q;
    assign host_tx_data = host_d_q;
    assign rts_n = radio_v_q;
    assign cmd_valid = cmd_v_q;
    assign cmd_data = cmd_d_q;
    assign cmd_remote = cmd_rem_q;
    assign link_up = link_q;
    assign link_service = svc_q;
    assign gpio_oe = gpio_oe_q;
    assign tx_level = tx_level_q;
    assign stack_bypass = hci_q;
    assign usb_device_mode = hci_q && usb_q;
    assign modem_ctl_en = (profile_q != 3'h0) && (profile_q <= `PROF_MDM);
    assign hid_en = (profile_q == `PROF_HID);
    assign cmd_mode = to_cmd;

    // checks
    sequence s_three_dollars;
        (host_take && host_rx_data == `DOLLAR && esc_q == ESC_TWO && local_ok && !hci_q && !exit_q);
    endsequence

    chk_gpio_all_in: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `OFF_GPIO && pwdata[15:0] == `GPIO_ALL_IN) |=> (gpio_oe == 12'h000))
        else $error("gpio not all inputs");
    chk_level_held: assert property (@(posedge pclk) disable iff (!presetn)
        (!reboot_q) |=> $stable(tx_level))
        else $error("tx level changed without reboot");
    chk_level_bound: assert property (@(posedge pclk) disable iff (!presetn)
        $past(reboot_q) && signed'(tx_code_q) >= signed'(`TX_MIN) && $stable(tx_code_q)
        |-> (signed'(tx_level) <= signed'(tx_code_q)) && (tx_level[1:0] == 2'h0))
        else $error("tx level above stored code");
    chk_master_remote: assert property (@(posedge pclk) disable iff (!presetn)
        (role_q != ROLE_SLAVE) |-> !remote_ok)
        else $error("remote timer not zero in master mode");
    chk_window_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (host_take && !to_cmd) |=> (radio_tx_valid && radio_tx_data == $past(host_rx_data) && !cmd_valid))
        else $error("pass-through byte lost or interpreted");
    chk_remote_expiry: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_valid && cmd_remote) |-> $past(remote_ok))
        else $error("remote config after expiry");
    chk_escape_entry: assert property (@(posedge pclk) disable iff (!presetn)
        s_three_dollars |=> cmd_mode)
        else $error("escape not entered");
    chk_boot_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (!cmd_ready_q) |-> (esc_q == ESC_IDLE))
        else $error("command entry before boot delay");
    chk_one_service: assert property (@(posedge pclk) disable iff (!presetn)
        (link_up && !conn_drop && !idle_drop) |=> ($stable(link_service) && link_up))
        else $error("service changed while connected");
    chk_idle_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (idle_drop && !conn_drop) |=> !link_up)
        else $error("idle link not dropped");
    chk_timer_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `OFF_TIMER) |=> (timer_q == $past(pwdata[7:0])))
        else $error("timer value not stored");
endmodule

`default_nettype wire

// ### verif/host_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gate_defines.svh"
// host processor on the serial side of the module
module host_mcu_model #(
    parameter int DELAY_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic host_rx_ready,
    input wire logic rts_n,
    input wire logic host_tx_valid,
    input wire logic [7:0] host_tx_data,
    output logic host_rx_valid,
    output logic [7:0] host_rx_data,
    output logic cts_n,
    output logic [7:0] got_data,
    output int got_cnt
);
    int since_q;
    logic seen_q;
    initial begin
        host_rx_valid = 1'b0;
        host_rx_data = 8'h00;
    end
    // boot delay and the flow control pin, low unless stalling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_q <= 0;
            cts_n <= 1'b0;
        end else begin
            if (since_q < DELAY_CYCLES)
                since_q <= since_q + 1;
            cts_n <= stall;
        end
    end
    // bytes arriving from the module
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
            got_cnt <= 0;
            got_data <= 8'h00;
        end else begin
            seen_q <= host_tx_valid;
            if (host_tx_valid && !seen_q) begin
                got_cnt <= got_cnt + 1;
                got_data <= host_tx_data;
            end
        end
    end
    // one byte, held until taken, never while the module is busy
    task automatic send(input logic [7:0] b);
        @(posedge pclk);
        while (since_q < DELAY_CYCLES || rts_n !== 1'b0)
            @(posedge pclk);
        host_rx_valid <= 1'b1;
        host_rx_data <= b;
        do @(posedge pclk); while (host_rx_ready !== 1'b1);
        host_rx_valid <= 1'b0;
        host_rx_data <= ~b;
    endtask
    // three dollars with no line ending
    task automatic escape();
        repeat (3) send(`DOLLAR);
    endtask
endmodule
`default_nettype wire

// ### verif/tb_config_gate_and_tx_power_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_gate_defines.svh"
module tb_config_gate_and_tx_power_ctl;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, radio_tx_ready, remote_rx_valid, stall, perr;
    logic conn_req_serial, conn_req_dialup, conn_drop;
    logic [7:0] paddr, remote_rx_data, host_rx_data, radio_tx_data, host_tx_data, cmd_data, got_data;
    logic [31:0] pwdata, prdata, st;
    logic pready, pslverr, host_rx_valid, host_rx_ready, radio_tx_valid, remote_rx_ready, host_tx_valid;
    logic cts_n, rts_n, cmd_valid, cmd_remote, link_up, stack_bypass, usb_device_mode, modem_ctl_en;
    logic hid_en, cmd_mode;
    logic [8:0] cmd_last;
    logic [1:0] link_service;
    logic [11:0] gpio_oe;
    logic [15:0] tx_level;
    int error_cnt = 0;
    int n_compared = 0;
    int radio_cnt = 0;
    int cmd_cnt = 0;
    int got_cnt;

    always #12.5 pclk = ~pclk;

    config_gate_and_tx_power_ctl #(.TICK_CYCLES(20), .CMD_DELAY_CYCLES(10)) u_config_gate_and_tx_power_ctl (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .host_rx_valid, .host_rx_data, .host_rx_ready, .radio_tx_valid, .radio_tx_data, .radio_tx_ready,
        .remote_rx_valid, .remote_rx_data, .remote_rx_ready, .host_tx_valid, .host_tx_data, .cts_n, .rts_n,
        .cmd_valid, .cmd_data, .cmd_remote, .conn_req_serial, .conn_req_dialup, .conn_drop, .link_up,
        .link_service, .gpio_oe, .tx_level, .stack_bypass, .usb_device_mode, .modem_ctl_en, .hid_en, .cmd_mode
    );
    host_mcu_model #(.DELAY_CYCLES(10)) u_host_mcu_model (
        .pclk, .presetn, .stall, .host_rx_ready, .rts_n, .host_tx_valid, .host_tx_data,
        .host_rx_valid, .host_rx_data, .cts_n, .got_data, .got_cnt
    );

    // count radio bytes and interpreter strobes
    always @(posedge pclk) begin
        if (radio_tx_valid === 1'b1 && radio_tx_ready === 1'b1)
            radio_cnt++;
        if (cmd_valid === 1'b1) begin
            cmd_cnt++;
            cmd_last = {cmd_remote, cmd_data};
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one bus transfer, held until pready, result in st and perr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        st = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(st, exp);
    endtask

    // one pulse on the connection inputs: serial, dialup, drop
    task automatic conn(input logic [2:0] v);
        @(posedge pclk);
        {conn_req_serial, conn_req_dialup, conn_drop} <= v;
        @(posedge pclk);
        {conn_req_serial, conn_req_dialup, conn_drop} <= 3'b000;
        @(negedge pclk);
    endtask

    // one byte from the radio peer, held until taken
    task automatic remote(input logic [7:0] b);
        @(posedge pclk);
        remote_rx_valid <= 1'b1;
        remote_rx_data <= b;
        do @(posedge pclk); while (remote_rx_ready !== 1'b1 || link_up !== 1'b1);
        remote_rx_valid <= 1'b0;
        remote_rx_data <= ~b;
    endtask

    task automatic t_reset_vals();
        rdc(`OFF_TX_STORED, 32'h10);
        rdc(`OFF_TX_ACTIVE, 32'h10);
        rdc(`OFF_TIMER, 32'h3c);
        rdc(`OFF_PROFILE, 32'h0);
        chk(tx_level, 16'h0010);
        chk(pready, 1'b1);
        rdc(8'h20, 32'h0);
        chk(perr, 1'b1);
    endtask

    task automatic t_power();
        logic [15:0] code[6] = '{16'h0013, 16'h000e, 16'h0007, 16'hfffd, 16'hfff0, 16'h0000};
        logic [15:0] lvl[6] = '{16'h0010, 16'h000c, 16'h0004, 16'hfffc, 16'hfff4, 16'h0000};
        logic [15:0] prev;
        prev = 16'h0010;
        foreach (code[i]) begin
            wr(`OFF_TX_STORED, {16'h0, code[i]});
            rdc(`OFF_TX_ACTIVE, {16'h0, prev});
            wr(`OFF_CTRL, 32'h100);
            repeat (3) @(negedge pclk);
            rdc(`OFF_TX_ACTIVE, {16'h0, lvl[i]});
            chk(tx_level, lvl[i]);
            rdc(`OFF_TX_STORED, {16'h0, code[i]});
            prev = lvl[i];
        end
    endtask

    task automatic t_gpio_prof();
        wr(`OFF_GPIO, 32'hfff);
        chk(gpio_oe, 12'hfff);
        wr(`OFF_GPIO, {16'h0, `GPIO_ALL_IN});
        chk(gpio_oe, 12'h000);
        for (int p = 0; p < 8; p++) begin
            wr(`OFF_PROFILE, p);
            rdc(`OFF_PROFILE, p < 7 ? p : 6);
            chk(modem_ctl_en, p >= 1 && p <= 3);
            chk(hid_en, p >= 6);
        end
    endtask

    task automatic t_cmd();
        int r0;
        int c0;
        rd(`OFF_STATUS);
        chk(st[3], 1'b1);
        r0 = radio_cnt;
        c0 = cmd_cnt;
        u_host_mcu_model.escape();
        repeat (2) @(negedge pclk);
        chk(cmd_mode, 1'b1);
        u_host_mcu_model.send(8'h41);
        repeat (2) @(negedge pclk);
        chk(cmd_cnt - c0, 1);
        chk(cmd_last, 9'h041);
        chk(radio_cnt - r0, 3);
        wr(`OFF_CTRL, 32'h200);
        repeat (2) @(negedge pclk);
        chk(cmd_mode, 1'b0);
    endtask

    task automatic t_timer();
        logic [7:0] v[5] = '{8'h00, 8'hfc, 8'hfd, 8'hfe, 8'hff};
        logic [1:0] ok[5] = '{2'b00, 2'b11, 2'b01, 2'b10, 2'b11};
        // decode seen with the link up, so remote access can show
        conn(3'b100);
        foreach (v[i]) begin
            wr(`OFF_TIMER, {24'h0, v[i]});
            rdc(`OFF_TIMER, {24'h0, v[i]});
            rd(`OFF_STATUS);
            chk(st[2:1], ok[i]);
        end
        conn(3'b001);
    endtask

    task automatic t_roles();
        int c0;
        conn(3'b100);
        for (int r = 0; r < 4; r++) begin
            wr(`OFF_CTRL, r);
            rd(`OFF_STATUS);
            chk(st[2], r == 0);
        end
        wr(`OFF_CTRL, 32'h0);
        c0 = cmd_cnt;
        remote(8'h52);
        repeat (2) @(negedge pclk);
        chk(cmd_cnt - c0, 1);
        chk(cmd_last, 9'h152);
        wr(`OFF_CTRL, 32'h1);
        @(posedge pclk);
        stall <= 1'b1;
        // let the stall pass the pin synchroniser first
        repeat (4) @(posedge pclk);
        remote(8'h33);
        repeat (8) @(negedge pclk);
        chk(host_tx_valid, 1'b1);
        chk(got_data, 8'h33);
        @(posedge pclk);
        stall <= 1'b0;
        repeat (6) @(negedge pclk);
        chk(host_tx_valid, 1'b0);
        conn(3'b001);
        conn(3'b110);
        chk(link_service, 2'd1);
        conn(3'b010);
        chk(link_service, 2'd1);
        conn(3'b001);
        conn(3'b010);
        chk(link_service, 2'd2);
        conn(3'b001);
    endtask

    task automatic t_idle_hci();
        wr(`OFF_TIMER, 32'h1);
        wr(`OFF_CTRL, 32'h2);
        conn(3'b100);
        chk(link_up, 1'b1);
        repeat (60) @(negedge pclk);
        chk(link_up, 1'b0);
        rd(`OFF_LINK);
        chk(st[2:0], 3'b000);
        wr(`OFF_CTRL, 32'h30);
        chk(stack_bypass, 1'b1);
        chk(usb_device_mode, 1'b1);
        wr(`OFF_CTRL, 32'h10);
        chk(usb_device_mode, 1'b0);
        wr(`OFF_CTRL, 32'h0);
        chk(stack_bypass, 1'b0);
    endtask

    task automatic t_expiry();
        int r0;
        logic [7:0] s0;
        wr(`OFF_TIMER, 32'h2);
        rd(`OFF_STATUS);
        chk(st[2:0], 3'b000);
        s0 = st[15:8];
        repeat (37) @(negedge pclk);
        rd(`OFF_STATUS);
        chk(st[15:8] - s0, 8'h02);
        r0 = radio_cnt;
        u_host_mcu_model.escape();
        u_host_mcu_model.send(8'h41);
        repeat (2) @(negedge pclk);
        chk(cmd_mode, 1'b0);
        chk(radio_cnt - r0, 4);
        chk(radio_tx_data, 8'h41);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, remote_rx_valid, stall} = '0;
        {conn_req_serial, conn_req_dialup, conn_drop} = '0;
        radio_tx_ready = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        remote_rx_data = 8'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_cmd();
        t_power();
        t_gpio_prof();
        t_timer();
        t_roles();
        t_idle_hci();
        t_expiry();
        report_and_stop();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
